// [include/cpurf_pkg.sv]
// package: constants and types for the core register file
package cpurf_pkg;
  // register bank and memory layout
  localparam logic [7:0] SP_RST = 8'h07;
  localparam logic [15:0] PC_RST = 16'h0000;
  localparam logic [1:0] BANK_RST = 2'h0;
  localparam logic [7:0] SFR_BASE = 8'h80;
  localparam logic [7:0] BIT_RAM_BASE = 8'h20;
  localparam logic [15:0] VEC_BASE = 16'h0003;
  localparam int VEC_SHIFT = 3;
  localparam int RAM_DEPTH = 256;
  // special-function region offsets
  localparam logic [7:0] SFR_SP = 8'h81;
  localparam logic [7:0] SFR_DPL = 8'h82;
  localparam logic [7:0] SFR_DPH = 8'h83;
  localparam logic [7:0] SFR_PSW = 8'hd0;
  localparam logic [7:0] SFR_ACC = 8'he0;
  localparam logic [7:0] SFR_B = 8'hf0;
  // status word field positions and the bit-test operand bit
  localparam int PSW_CY = 7;
  localparam int PSW_AC = 6;
  localparam int PSW_F0 = 5;
  localparam int PSW_RS_HI = 4;
  localparam int PSW_RS_LO = 3;
  localparam int PSW_OV = 2;
  localparam int PSW_F1 = 1;
  localparam int PSW_P = 0;
  localparam int OPND_BIT6 = 6;

  typedef enum logic [3:0] {
    ACC_NONE, ACC_DIR_RD, ACC_DIR_WR, ACC_IND_RD, ACC_IND_WR, ACC_BIT_RD, ACC_BIT_WR,
    ACC_REG_RD, ACC_REG_WR, ACC_PUSH, ACC_POP
  } cpurf_mem_op_t;

  typedef enum logic [3:0] {
    ALU_NONE, ALU_ADD, ALU_ADDC, ALU_SUBB, ALU_RLC, ALU_RRC, ALU_MUL, ALU_DIV, ALU_CLR_OV, ALU_BIT_TEST
  } cpurf_alu_op_t;

  typedef enum logic [1:0] {PC_HOLD, PC_INC, PC_LOAD, PC_VECTOR} cpurf_pc_op_t;

  typedef struct packed {
    cpurf_mem_op_t op;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic bit_val;
  } cpurf_mem_req_t;

  typedef struct packed {
    cpurf_alu_op_t op;
    logic [7:0] operand;
  } cpurf_alu_req_t;

  typedef struct packed {
    cpurf_pc_op_t op;
    logic [15:0] target;
    logic [1:0] vec_idx;
  } cpurf_pc_req_t;

  typedef struct packed {
    logic [7:0] acc;
    logic [7:0] b;
    logic [7:0] sp;
    logic [7:0] program_status_word;
    logic [15:0] data_pointer;
    logic [15:0] pc;
  } cpurf_state_t;
endpackage

// [verilog/cpurf_core.sv]
// core register file: accumulator, b, stack, status word, pointers and internal ram
// How it works
// - stack pointer 8-bit, pre-increments on push
// - reset loads stack pointer with 07h
// - program counter is 16 bits, high/low
// - after reset fetch starts at 0000h
// - carry captures adder carry, shifts, rotates
// - aux carry from bit 3 carry
// - two bank bits pick one of four banks
// - overflow set on signed result out of range
// - clear-overflow op; bit test copies bit 6
// - parity makes accumulator ones count even
// - accumulator pairs with b as 16 bits
// - b holds second operand for multiply/divide
// - data pointer 16-bit, addresses external data
// - interrupt vectors 0003h spaced eight bytes
// - 256-byte internal ram holds the stack
// - special-function region direct addressing only
// - bytes 32..47 give 128 bit locations
// - bytes 0..31 hold four register banks
// - separate program and data address spaces
// - flash writes only during programming
`timescale 1ns/1ns
`default_nettype none
module cpurf_core (
  input wire logic clk,
  input wire logic srst,
  input wire cpurf_pkg::cpurf_mem_req_t mem_req,
  input wire cpurf_pkg::cpurf_alu_req_t alu_req,
  input wire cpurf_pkg::cpurf_pc_req_t pc_req,
  input wire logic flash_wr_req,
  input wire logic flash_prog_active,
  output cpurf_pkg::cpurf_state_t core_state,
  output logic [7:0] rd_data,
  output logic rd_valid,
  output logic [15:0] code_addr,
  output logic [15:0] xdata_addr,
  output logic [15:0] acc_b_pair,
  output logic flash_wr_en,
  output logic [15:0] flash_wr_addr,
  output logic [7:0] flash_wr_data
);
  logic [7:0] acc_r, acc_nxt, b_r, b_nxt, sp_r, sp_nxt, dph_r, dph_nxt, dpl_r, dpl_nxt;
  logic cy_r, cy_nxt, ac_r, ac_nxt, f0_r, f0_nxt, ov_r, ov_nxt, f1_r, f1_nxt;
  logic [1:0] rs_r, rs_nxt;
  logic [15:0] pc_r, pc_nxt;
  logic [7:0] ram_r [cpurf_pkg::RAM_DEPTH];
  logic [7:0] ram_nxt [cpurf_pkg::RAM_DEPTH];
  logic [7:0] rd_data_r, rd_data_nxt;
  logic rd_valid_r, rd_valid_nxt;
  logic flash_we_r, flash_we_nxt;
  logic [15:0] flash_addr_r, flash_addr_nxt;
  logic [7:0] flash_data_r, flash_data_nxt;
  logic parity;
  logic [7:0] program_status_word;

  assign parity = ^acc_r;
  assign program_status_word = {cy_r, ac_r, f0_r, rs_r, ov_r, f1_r, parity};

  // direct read: low half is ram, upper half is the special-function region
  function automatic logic [7:0] dir_read(input logic [7:0] a);
    logic [7:0] v;
    v = 8'h00;
    if (a < cpurf_pkg::SFR_BASE) begin
      v = ram_r[a];
    end else if (a == cpurf_pkg::SFR_ACC) begin
      v = acc_r;
    end else if (a == cpurf_pkg::SFR_B) begin
      v = b_r;
    end else if (a == cpurf_pkg::SFR_PSW) begin
      v = program_status_word;
    end else if (a == cpurf_pkg::SFR_SP) begin
      v = sp_r;
    end else if (a == cpurf_pkg::SFR_DPL) begin
      v = dpl_r;
    end else if (a == cpurf_pkg::SFR_DPH) begin
      v = dph_r;
    end
    return v;
  endfunction

  always_comb begin
    logic [8:0] sum9;
    logic [4:0] nib5;
    logic [15:0] prod;
    logic [7:0] ea, bv, wd;
    logic wen, wdir;
    sum9 = 9'h000;
    nib5 = 5'h00;
    prod = 16'h0000;
    ea = 8'h00;
    bv = 8'h00;
    wd = 8'h00;
    wen = 1'b0;
    wdir = 1'b0;
    acc_nxt = acc_r;
    b_nxt = b_r;
    sp_nxt = sp_r;
    dph_nxt = dph_r;
    dpl_nxt = dpl_r;
    cy_nxt = cy_r;
    ac_nxt = ac_r;
    f0_nxt = f0_r;
    ov_nxt = ov_r;
    f1_nxt = f1_r;
    rs_nxt = rs_r;
    pc_nxt = pc_r;
    ram_nxt = ram_r;
    rd_data_nxt = rd_data_r;
    rd_valid_nxt = 1'b0;
    flash_we_nxt = 1'b0;
    flash_addr_nxt = flash_addr_r;
    flash_data_nxt = flash_data_r;
    // arithmetic unit
    case (alu_req.op)
      cpurf_pkg::ALU_ADD, cpurf_pkg::ALU_ADDC: begin
        sum9 = {1'b0, acc_r} + {1'b0, alu_req.operand} + {8'h00, alu_req.op == cpurf_pkg::ALU_ADDC && cy_r};
        nib5 = {1'b0, acc_r[3:0]} + {1'b0, alu_req.operand[3:0]} + {4'h0, alu_req.op == cpurf_pkg::ALU_ADDC && cy_r};
        acc_nxt = sum9[7:0];
        cy_nxt = sum9[8];
        ac_nxt = nib5[4];
        ov_nxt = (acc_r[7] == alu_req.operand[7]) && (sum9[7] != acc_r[7]);
      end
      cpurf_pkg::ALU_SUBB: begin
        sum9 = {1'b0, acc_r} - {1'b0, alu_req.operand} - {8'h00, cy_r};
        nib5 = {1'b0, acc_r[3:0]} - {1'b0, alu_req.operand[3:0]} - {4'h0, cy_r};
        acc_nxt = sum9[7:0];
        cy_nxt = ~sum9[8];
        ac_nxt = ~nib5[4];
        ov_nxt = (acc_r[7] != alu_req.operand[7]) && (sum9[7] != acc_r[7]);
      end
      cpurf_pkg::ALU_RLC: begin
        acc_nxt = {acc_r[6:0], cy_r};
        cy_nxt = acc_r[7];
      end
      cpurf_pkg::ALU_RRC: begin
        acc_nxt = {cy_r, acc_r[7:1]};
        cy_nxt = acc_r[0];
      end
      cpurf_pkg::ALU_MUL: begin
        prod = acc_r * b_r;
        acc_nxt = prod[7:0];
        b_nxt = prod[15:8];
        cy_nxt = 1'b0;
        ov_nxt = |prod[15:8];
      end
      cpurf_pkg::ALU_DIV: begin
        cy_nxt = 1'b0;
        ov_nxt = (b_r == 8'h00);
        if (b_r != 8'h00) begin
          acc_nxt = acc_r / b_r;
          b_nxt = acc_r % b_r;
        end
      end
      cpurf_pkg::ALU_CLR_OV: begin
        ov_nxt = 1'b0;
      end
      cpurf_pkg::ALU_BIT_TEST: begin
        ov_nxt = alu_req.operand[cpurf_pkg::OPND_BIT6];
      end
      default: begin
      end
    endcase
    // data-space access; a write here wins over the arithmetic unit
    case (mem_req.op)
      cpurf_pkg::ACC_DIR_RD: begin
        rd_data_nxt = dir_read(mem_req.addr);
        rd_valid_nxt = 1'b1;
      end
      cpurf_pkg::ACC_DIR_WR: begin
        wen = 1'b1;
        wdir = 1'b1;
        ea = mem_req.addr;
        wd = mem_req.wdata;
      end
      cpurf_pkg::ACC_IND_RD: begin
        rd_data_nxt = ram_r[mem_req.addr];
        rd_valid_nxt = 1'b1;
      end
      cpurf_pkg::ACC_IND_WR: begin
        wen = 1'b1;
        ea = mem_req.addr;
        wd = mem_req.wdata;
      end
      cpurf_pkg::ACC_BIT_RD, cpurf_pkg::ACC_BIT_WR: begin
        if (mem_req.addr < cpurf_pkg::SFR_BASE) begin
          ea = cpurf_pkg::BIT_RAM_BASE + {4'h0, mem_req.addr[6:3]};
        end else begin
          ea = {mem_req.addr[7:3], 3'h0};
        end
        bv = dir_read(ea);
        if (mem_req.op == cpurf_pkg::ACC_BIT_RD) begin
          rd_data_nxt = {7'h00, bv[mem_req.addr[2:0]]};
          rd_valid_nxt = 1'b1;
        end else begin
          bv[mem_req.addr[2:0]] = mem_req.bit_val;
          wen = 1'b1;
          wdir = 1'b1;
          wd = bv;
        end
      end
      cpurf_pkg::ACC_REG_RD: begin
        rd_data_nxt = ram_r[{3'h0, rs_r, mem_req.addr[2:0]}];
        rd_valid_nxt = 1'b1;
      end
      cpurf_pkg::ACC_REG_WR: begin
        wen = 1'b1;
        ea = {3'h0, rs_r, mem_req.addr[2:0]};
        wd = mem_req.wdata;
      end
      cpurf_pkg::ACC_PUSH: begin
        sp_nxt = sp_r + 8'h01;
        ram_nxt[sp_r + 8'h01] = mem_req.wdata;
      end
      cpurf_pkg::ACC_POP: begin
        rd_data_nxt = ram_r[sp_r];
        rd_valid_nxt = 1'b1;
        sp_nxt = sp_r - 8'h01;
      end
      default: begin
      end
    endcase
    if (wen) begin
      if (!wdir || ea < cpurf_pkg::SFR_BASE) begin
        ram_nxt[ea] = wd;
      end else if (ea == cpurf_pkg::SFR_ACC) begin
        acc_nxt = wd;
      end else if (ea == cpurf_pkg::SFR_B) begin
        b_nxt = wd;
      end else if (ea == cpurf_pkg::SFR_PSW) begin
        cy_nxt = wd[cpurf_pkg::PSW_CY];
        ac_nxt = wd[cpurf_pkg::PSW_AC];
        f0_nxt = wd[cpurf_pkg::PSW_F0];
        rs_nxt = {wd[cpurf_pkg::PSW_RS_HI], wd[cpurf_pkg::PSW_RS_LO]};
        ov_nxt = wd[cpurf_pkg::PSW_OV];
        f1_nxt = wd[cpurf_pkg::PSW_F1];
      end else if (ea == cpurf_pkg::SFR_SP) begin
        sp_nxt = wd;
      end else if (ea == cpurf_pkg::SFR_DPL) begin
        dpl_nxt = wd;
      end else if (ea == cpurf_pkg::SFR_DPH) begin
        dph_nxt = wd;
      end
    end
    // program counter
    case (pc_req.op)
      cpurf_pkg::PC_INC: begin
        pc_nxt = pc_r + 16'h0001;
      end
      cpurf_pkg::PC_LOAD: begin
        pc_nxt = pc_req.target;
      end
      cpurf_pkg::PC_VECTOR: begin
        pc_nxt = cpurf_pkg::VEC_BASE + ({14'h0000, pc_req.vec_idx} << cpurf_pkg::VEC_SHIFT);
      end
      default: begin
      end
    endcase
    // program-space writes pass only while programming
    if (flash_wr_req && flash_prog_active) begin
      flash_we_nxt = 1'b1;
      flash_addr_nxt = {dph_r, dpl_r};
      flash_data_nxt = acc_r;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      acc_r <= 8'h00;
      b_r <= 8'h00;
      sp_r <= cpurf_pkg::SP_RST;
      dph_r <= 8'h00;
      dpl_r <= 8'h00;
      cy_r <= 1'b0;
      ac_r <= 1'b0;
      f0_r <= 1'b0;
      ov_r <= 1'b0;
      f1_r <= 1'b0;
      rs_r <= cpurf_pkg::BANK_RST;
      pc_r <= cpurf_pkg::PC_RST;
      rd_data_r <= 8'h00;
      rd_valid_r <= 1'b0;
      flash_we_r <= 1'b0;
      flash_addr_r <= 16'h0000;
      flash_data_r <= 8'h00;
    end else begin
      acc_r <= acc_nxt;
      b_r <= b_nxt;
      sp_r <= sp_nxt;
      dph_r <= dph_nxt;
      dpl_r <= dpl_nxt;
      cy_r <= cy_nxt;
      ac_r <= ac_nxt;
      f0_r <= f0_nxt;
      ov_r <= ov_nxt;
      f1_r <= f1_nxt;
      rs_r <= rs_nxt;
      pc_r <= pc_nxt;
      rd_data_r <= rd_data_nxt;
      rd_valid_r <= rd_valid_nxt;
      flash_we_r <= flash_we_nxt;
      flash_addr_r <= flash_addr_nxt;
      flash_data_r <= flash_data_nxt;
    end
  end

  // ram contents are not cleared by reset
  always_ff @(posedge clk) begin
    ram_r <= ram_nxt;
  end

  assign core_state = '{acc: acc_r, b: b_r, sp: sp_r, program_status_word: program_status_word, data_pointer: {dph_r, dpl_r}, pc: pc_r};
  assign rd_data = rd_data_r;
  assign rd_valid = rd_valid_r;
  assign code_addr = pc_r;
  assign xdata_addr = {dph_r, dpl_r};
  assign acc_b_pair = {b_r, acc_r};
  assign flash_wr_en = flash_we_r;
  assign flash_wr_addr = flash_addr_r;
  assign flash_wr_data = flash_data_r;

  sp_reset_a: assert property (@(posedge clk) $past(srst) |-> sp_r == cpurf_pkg::SP_RST && rs_r == 2'h0)
    else $error("stack pointer or bank not at reset value");
  pc_reset_a: assert property (@(posedge clk) srst ##1 !srst |-> pc_r == 16'h0000)
    else $error("program counter not cleared by reset");
  push_stack_a: assert property (@(posedge clk) disable iff (srst)
    mem_req.op == cpurf_pkg::ACC_PUSH |=> sp_r == $past(sp_r) + 8'h01 && ram_r[sp_r] == $past(mem_req.wdata))
    else $error("push did not pre-increment and store");
  vector_pc_a: assert property (@(posedge clk) disable iff (srst)
    pc_req.op == cpurf_pkg::PC_VECTOR && pc_req.vec_idx == 2'h1 |=> pc_r == 16'h000b)
    else $error("timer vector address wrong");
  parity_even_a: assert property (@(posedge clk) disable iff (srst) ^{acc_r, program_status_word[cpurf_pkg::PSW_P]} == 1'b0)
    else $error("parity flag does not make an even count");
  clear_ov_a: assert property (@(posedge clk) disable iff (srst)
    alu_req.op == cpurf_pkg::ALU_CLR_OV && mem_req.op != cpurf_pkg::ACC_DIR_WR && mem_req.op != cpurf_pkg::ACC_BIT_WR
    |=> !ov_r)
    else $error("overflow not cleared");
  flash_gate_a: assert property (@(posedge clk) disable iff (srst)
    flash_wr_en |-> $past(flash_prog_active) && $past(flash_wr_req))
    else $error("flash write outside programming");
  ind_ram_a: assert property (@(posedge clk) disable iff (srst)
    mem_req.op == cpurf_pkg::ACC_IND_RD |=> rd_valid && rd_data == $past(ram_r[mem_req.addr]))
    else $error("indirect read did not return ram");
  bank_write_a: assert property (@(posedge clk) disable iff (srst)
    mem_req.op == cpurf_pkg::ACC_REG_WR |=> ram_r[{3'h0, $past(rs_r), $past(mem_req.addr[2:0])}] == $past(mem_req.wdata))
    else $error("register write missed the selected bank");
  add_carry_a: assert property (@(posedge clk) disable iff (srst)
    alu_req.op == cpurf_pkg::ALU_ADD && mem_req.op == cpurf_pkg::ACC_NONE
    |=> cy_r == (({1'b0, $past(acc_r)} + {1'b0, $past(alu_req.operand)}) > 9'h0ff))
    else $error("carry does not match addition");
endmodule
`default_nettype wire

// [test/cpurf_core_tb.sv]
// testbench for the core register file
`timescale 1ns/1ns
`default_nettype none
module cpurf_core_tb;
  typedef struct packed {
    cpurf_pkg::cpurf_mem_req_t m;
    cpurf_pkg::cpurf_alu_req_t a;
    logic [7:0] acc;
    logic [7:0] b;
    logic [7:0] sp;
    logic [7:0] program_status_word;
    logic [7:0] rd;
  } cpurf_row_t;
  localparam cpurf_pkg::cpurf_mem_op_t mn = cpurf_pkg::ACC_NONE;
  localparam cpurf_pkg::cpurf_mem_op_t dwr = cpurf_pkg::ACC_DIR_WR;
  localparam cpurf_pkg::cpurf_mem_op_t drd = cpurf_pkg::ACC_DIR_RD;
  localparam cpurf_pkg::cpurf_alu_op_t an = cpurf_pkg::ALU_NONE;
  logic clk;
  logic srst;
  cpurf_pkg::cpurf_mem_req_t mem_req;
  cpurf_pkg::cpurf_alu_req_t alu_req;
  cpurf_pkg::cpurf_pc_req_t pc_req;
  logic flash_wr_req;
  logic flash_prog_active;
  cpurf_pkg::cpurf_state_t st;
  logic [7:0] rd_data;
  logic rd_valid;
  logic [15:0] code_addr;
  logic [15:0] xdata_addr;
  logic [15:0] acc_b_pair;
  logic flash_wr_en;
  logic [15:0] flash_wr_addr;
  logic [7:0] flash_wr_data;
  int err_total;
  int n_tests;
  int cyc;
  cpurf_row_t rows[$];
  cpurf_row_t e;
  logic is_rd;

  cpurf_core cpurf_core_i (
    .clk(clk),
    .srst(srst),
    .mem_req(mem_req),
    .alu_req(alu_req),
    .pc_req(pc_req),
    .flash_wr_req(flash_wr_req),
    .flash_prog_active(flash_prog_active),
    .core_state(st),
    .rd_data(rd_data),
    .rd_valid(rd_valid),
    .code_addr(code_addr),
    .xdata_addr(xdata_addr),
    .acc_b_pair(acc_b_pair),
    .flash_wr_en(flash_wr_en),
    .flash_wr_addr(flash_wr_addr),
    .flash_wr_data(flash_wr_data)
  );

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic chk(input logic [79:0] seen, input logic [79:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task end_of_test;
    $display("comparisons=%0d mismatches=%0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // one table row: request, then expected acc, b, sp, psw flags and read data
  task automatic q(cpurf_pkg::cpurf_mem_op_t mo, logic [7:0] ad, logic [7:0] wd, cpurf_pkg::cpurf_alu_op_t ao,
                   logic [7:0] od, logic [7:0] ea, logic [7:0] eb, logic [7:0] es, logic [7:0] ep, logic [7:0] er);
    rows.push_back('{'{mo, ad, wd, wd[0]}, '{ao, od}, ea, eb, es, ep, er});
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 1000) begin
      err_total++;
      end_of_test;
    end
  end

  initial begin
    srst = 1'b1;
    mem_req = '{mn, 8'h0, 8'h0, 1'b0};
    alu_req = '{an, 8'h0};
    pc_req = '{cpurf_pkg::PC_HOLD, 16'h0, 2'h0};
    flash_wr_req = 1'b0;
    flash_prog_active = 1'b0;
    q(dwr, 8'he0, 8'h3c, an, 8'h0, 8'h3c, 8'h0, 8'h07, 8'h0, 8'h0);
    q(mn, 8'h0, 8'h0, cpurf_pkg::ALU_ADD, 8'hc4, 8'h0, 8'h0, 8'h07, 8'hc0, 8'h0);
    q(dwr, 8'he0, 8'h40, an, 8'h0, 8'h40, 8'h0, 8'h07, 8'hc0, 8'h0);
    q(mn, 8'h0, 8'h0, cpurf_pkg::ALU_ADD, 8'h40, 8'h80, 8'h0, 8'h07, 8'h04, 8'h0);
    q(mn, 8'h0, 8'h0, cpurf_pkg::ALU_CLR_OV, 8'h0, 8'h80, 8'h0, 8'h07, 8'h0, 8'h0);
    q(mn, 8'h0, 8'h0, cpurf_pkg::ALU_BIT_TEST, 8'h40, 8'h80, 8'h0, 8'h07, 8'h04, 8'h0);
    q(mn, 8'h0, 8'h0, cpurf_pkg::ALU_SUBB, 8'h01, 8'h7f, 8'h0, 8'h07, 8'h84, 8'h0);
    q(mn, 8'h0, 8'h0, cpurf_pkg::ALU_RLC, 8'h0, 8'hff, 8'h0, 8'h07, 8'h04, 8'h0);
    q(mn, 8'h0, 8'h0, cpurf_pkg::ALU_RRC, 8'h0, 8'h7f, 8'h0, 8'h07, 8'h84, 8'h0);
    q(cpurf_pkg::ACC_PUSH, 8'h0, 8'h55, an, 8'h0, 8'h7f, 8'h0, 8'h08, 8'h84, 8'h0);
    q(cpurf_pkg::ACC_PUSH, 8'h0, 8'h66, an, 8'h0, 8'h7f, 8'h0, 8'h09, 8'h84, 8'h0);
    q(cpurf_pkg::ACC_POP, 8'h0, 8'h0, an, 8'h0, 8'h7f, 8'h0, 8'h08, 8'h84, 8'h66);
    q(cpurf_pkg::ACC_POP, 8'h0, 8'h0, an, 8'h0, 8'h7f, 8'h0, 8'h07, 8'h84, 8'h55);
    q(dwr, 8'hd0, 8'h19, an, 8'h0, 8'h7f, 8'h0, 8'h07, 8'h18, 8'h0);
    q(cpurf_pkg::ACC_REG_WR, 8'h02, 8'ha5, an, 8'h0, 8'h7f, 8'h0, 8'h07, 8'h18, 8'h0);
    q(drd, 8'h1a, 8'h0, an, 8'h0, 8'h7f, 8'h0, 8'h07, 8'h18, 8'ha5);
    q(dwr, 8'hd0, 8'h0, an, 8'h0, 8'h7f, 8'h0, 8'h07, 8'h0, 8'h0);
    q(cpurf_pkg::ACC_REG_WR, 8'h02, 8'hc3, an, 8'h0, 8'h7f, 8'h0, 8'h07, 8'h0, 8'h0);
    q(drd, 8'h02, 8'h0, an, 8'h0, 8'h7f, 8'h0, 8'h07, 8'h0, 8'hc3);
    q(cpurf_pkg::ACC_IND_WR, 8'h81, 8'h99, an, 8'h0, 8'h7f, 8'h0, 8'h07, 8'h0, 8'h0);
    q(drd, 8'h81, 8'h0, an, 8'h0, 8'h7f, 8'h0, 8'h07, 8'h0, 8'h07);
    q(cpurf_pkg::ACC_IND_RD, 8'h81, 8'h0, an, 8'h0, 8'h7f, 8'h0, 8'h07, 8'h0, 8'h99);
    q(dwr, 8'h21, 8'h0, an, 8'h0, 8'h7f, 8'h0, 8'h07, 8'h0, 8'h0);
    q(cpurf_pkg::ACC_BIT_WR, 8'h0f, 8'h01, an, 8'h0, 8'h7f, 8'h0, 8'h07, 8'h0, 8'h0);
    q(drd, 8'h21, 8'h0, an, 8'h0, 8'h7f, 8'h0, 8'h07, 8'h0, 8'h80);
    q(drd, 8'h85, 8'h0, an, 8'h0, 8'h7f, 8'h0, 8'h07, 8'h0, 8'h0);
    q(dwr, 8'hf0, 8'h03, an, 8'h0, 8'h7f, 8'h03, 8'h07, 8'h0, 8'h0);
    q(mn, 8'h0, 8'h0, cpurf_pkg::ALU_MUL, 8'h0, 8'h7d, 8'h01, 8'h07, 8'h04, 8'h0);
    q(dwr, 8'hf0, 8'h04, an, 8'h0, 8'h7d, 8'h04, 8'h07, 8'h04, 8'h0);
    q(mn, 8'h0, 8'h0, cpurf_pkg::ALU_DIV, 8'h0, 8'h1f, 8'h01, 8'h07, 8'h0, 8'h0);
    q(dwr, 8'hf0, 8'h0, an, 8'h0, 8'h1f, 8'h0, 8'h07, 8'h0, 8'h0);
    q(mn, 8'h0, 8'h0, cpurf_pkg::ALU_DIV, 8'h0, 8'h1f, 8'h0, 8'h07, 8'h04, 8'h0);
    q(dwr, 8'h83, 8'h12, an, 8'h0, 8'h1f, 8'h0, 8'h07, 8'h04, 8'h0);
    q(dwr, 8'h82, 8'h34, an, 8'h0, 8'h1f, 8'h0, 8'h07, 8'h04, 8'h0);
    q(cpurf_pkg::ACC_REG_RD, 8'h02, 8'h0, an, 8'h0, 8'h1f, 8'h0, 8'h07, 8'h04, 8'hc3);
    q(cpurf_pkg::ACC_BIT_RD, 8'h0f, 8'h0, an, 8'h0, 8'h1f, 8'h0, 8'h07, 8'h04, 8'h01);
    q(dwr, 8'hd0, 8'h80, an, 8'h0, 8'h1f, 8'h0, 8'h07, 8'h80, 8'h0);
    q(mn, 8'h0, 8'h0, cpurf_pkg::ALU_ADDC, 8'h01, 8'h21, 8'h0, 8'h07, 8'h40, 8'h0);
    repeat (6) @(negedge clk);
    srst = 1'b0;
    chk({st, rd_valid, flash_wr_en}, {8'h0, 8'h0, 8'h07, 8'h0, 16'h0, 16'h0, 2'b00});
    pc_req.op = cpurf_pkg::PC_INC;
    foreach (rows[i]) begin
      e = rows[i];
      mem_req = e.m;
      alu_req = e.a;
      is_rd = e.m.op inside {drd, cpurf_pkg::ACC_IND_RD, cpurf_pkg::ACC_REG_RD, cpurf_pkg::ACC_POP, cpurf_pkg::ACC_BIT_RD};
      @(negedge clk);
      chk({st.acc, st.b, st.sp, st.program_status_word}, {e.acc, e.b, e.sp, e.program_status_word[7:1], ^e.acc});
      chk({code_addr, acc_b_pair}, {16'(i + 1), e.b, e.acc});
      chk({rd_valid, is_rd ? rd_data : 8'h0}, {is_rd, e.rd});
    end
    mem_req.op = mn;
    alu_req.op = an;
    pc_req.op = cpurf_pkg::PC_VECTOR;
    for (int v = 0; v < 4; v++) begin
      pc_req.vec_idx = 2'(v);
      @(negedge clk);
      chk(code_addr, 16'h0003 + 16'(8 * v));
    end
    pc_req = '{cpurf_pkg::PC_LOAD, 16'hbeef, 2'h0};
    @(negedge clk);
    chk(code_addr, 16'hbeef);
    pc_req.op = cpurf_pkg::PC_HOLD;
    chk(xdata_addr, 16'h1234);
    flash_wr_req = 1'b1;
    @(negedge clk);
    chk(flash_wr_en, 1'b0);
    flash_prog_active = 1'b1;
    @(negedge clk);
    chk({flash_wr_en, flash_wr_addr, flash_wr_data}, {1'b1, 16'h1234, 8'h21});
    flash_wr_req = 1'b0;
    @(negedge clk);
    chk(flash_wr_en, 1'b0);
    mem_req = '{dwr, 8'hd0, 8'h18, 1'b0};
    @(negedge clk);
    chk(st.program_status_word[4:3], 2'h3);
    mem_req.op = mn;
    srst = 1'b1;
    @(negedge clk);
    srst = 1'b0;
    chk({st.sp, st.pc, st.program_status_word[4:3]}, {8'h07, 16'h0, 2'h0});
    end_of_test;
  end
endmodule
`default_nettype wire
